/* File: rtl/nand_host_pkg.sv */
// Shared constants, types and timing for the NAND read-path host controller.
package nand_host_pkg;

	// Clock rate and a helper that turns a least time into whole cycles.
	localparam int CLK_MHZ = 40;
	function automatic int least_cycles(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction : least_cycles

	// Pin timing in nanoseconds; plain defaults for a generic asynchronous part.
	localparam int WE_LOW_NS = 15;
	localparam int WE_HIGH_NS = 15;
	localparam int RE_LOW_NS = 15;
	localparam int RE_HIGH_NS = 15;
	localparam int WRITE_TO_READ_NS = 60;
	localparam int WE_TO_BUSY_NS = 100;
	localparam int WE_LOW_CYC = least_cycles(WE_LOW_NS);
	localparam int WE_HIGH_CYC = least_cycles(WE_HIGH_NS);
	localparam int RE_LOW_CYC = least_cycles(RE_LOW_NS);
	localparam int RE_HIGH_CYC = least_cycles(RE_HIGH_NS);
	localparam int WRITE_TO_READ_CYC = least_cycles(WRITE_TO_READ_NS);
	localparam int WE_TO_BUSY_CYC = least_cycles(WE_TO_BUSY_NS);
	localparam int SYNC_STAGES = 2;

	// Command codes placed on the bus.
	localparam logic [7:0] CMD_READ_SETUP = 8'h00;
	localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
	localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
	localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
	localparam logic [7:0] CMD_COL_CHANGE = 8'h05;
	localparam logic [7:0] CMD_PLANE_SELECT = 8'h06;
	localparam logic [7:0] CMD_OUT_CONFIRM = 8'hE0;
	localparam logic [7:0] CMD_READ_IDENT = 8'h90;
	localparam logic [7:0] CMD_PARAM_PAGE = 8'hEC;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] IDENT_ADDR_DEVICE = 8'h00;
	localparam logic [7:0] IDENT_ADDR_SIGNATURE = 8'h20;
	localparam logic [7:0] PARAM_ADDR = 8'h00;

	// Address layout, status bits and fixed output lengths.
	localparam int ROW_PLANE_BIT = 6;
	localparam int STATUS_CACHE_BIT = 6;
	localparam int STATUS_ARRAY_BIT = 5;
	localparam logic [15:0] IDENT_DEVICE_LEN = 16'h0005;
	localparam logic [15:0] IDENT_SIGNATURE_LEN = 16'h0004;
	localparam logic [15:0] STATUS_LEN = 16'h0001;

	// Operations a user may request.
	typedef enum logic [3:0] {
		OP_PAGE_READ, OP_CACHE_SEQ, OP_CACHE_RANDOM, OP_CACHE_LAST, OP_TWO_PLANE,
		OP_COL_CHANGE, OP_PLANE_SELECT, OP_IDENT_DEVICE, OP_IDENT_SIGNATURE,
		OP_PARAM_PAGE, OP_STATUS
	} op_t;

	// One user request: operation, column, row and number of bytes to strobe.
	typedef struct packed {
		op_t op;
		logic [15:0] col;
		logic [23:0] row;
		logic [15:0] count;
	} req_t;

	// One step of a pin sequence.
	typedef enum logic [2:0] {K_CMD, K_ADDR, K_BUSY, K_WAIT, K_READ, K_DONE} kind_t;
	typedef struct packed {
		kind_t kind;
		logic [7:0] data;
	} step_t;

endpackage : nand_host_pkg

/* File: rtl/read_buffer.sv */
// Small valid/ready FIFO that holds bytes read from the flash until the user takes them.
`timescale 1ns/10ps
module read_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// Filling side.
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Draining side.
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Pointers wrap by width, so the depth must be a power of two.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("read_buffer depth must be a power of two of at least two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] fill, next_fill;
	logic push, pop;

	// Full and empty follow the fill count exactly, so a stalled reader really blocks the writer.
	always_comb begin
		in_ready_out = (fill != (AW + 1)'(DEPTH));
		out_valid_out = (fill != '0);
		push = in_valid_in && in_ready_out;
		pop = out_valid_out && out_ready_in;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_fill = fill + (AW + 1)'(push) - (AW + 1)'(pop);
		out_data_out = mem[rd_ptr];
	end

	// Pointer and count registers.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fill <= next_fill;
		end
	end

	// Storage has no reset; empty entries are never presented as valid.
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end

endmodule : read_buffer

/* File: rtl/nand_read_host.sv */
// Host controller that drives the read-path command sequences of an asynchronous NAND flash.
//
// Summary of operation
// - Cache read starts: 00h, five addresses, 30h.
// - Random cache: 00h, five addresses, then 31h.
// - Two-plane: two address sets differing only plane.
// - Plane-select before reading each plane's data.
// - Never issue enhanced status during two-plane read.
// - Column change: 05h, two columns, E0h.
// - Plane select: wait ready, then 06h, five addresses, E0h.
// - Wait write-to-read delay after E0h before strobing.
`timescale 1ns/10ps
module nand_read_host #(
	parameter int DATA_WIDTH = 8,
	parameter int BUFFER_DEPTH = 2
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// User request port.
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire nand_host_pkg::req_t req_in,
	output logic done_out,
	// User read data stream.
	output logic data_valid_out,
	input wire logic data_ready_in,
	output logic [DATA_WIDTH-1:0] data_out,
	// Last status byte decoded.
	output logic cache_ready_out,
	output logic array_ready_out,
	// Flash pins.
	output logic ce_n_out,
	output logic cle_out,
	output logic ale_out,
	output logic we_n_out,
	output logic read_strobe_n_out,
	output logic [DATA_WIDTH-1:0] io_out,
	output logic io_oe_n_out,
	input wire logic [DATA_WIDTH-1:0] io_in,
	input wire logic ready_busy_in
);
	if (DATA_WIDTH != 8 && DATA_WIDTH != 16) begin : g_bad_width
		$error("nand_read_host supports only 8 or 16 bit buses");
	end

	typedef enum logic [3:0] {
		S_IDLE, S_STEP, S_WR_LO, S_WR_HI, S_WB, S_BUSY, S_WAIT, S_RD_ARM, S_RD_LO, S_RD_HI
	} state_t;

	// Byte n of the five-cycle address: two column cycles then three row cycles.
	function automatic logic [7:0] addr_byte(input nand_host_pkg::req_t r, input int n);
		logic [7:0] b;
		b = 8'h00;
		case (n)
			0: b = r.col[7:0];
			1: b = r.col[15:8];
			2: b = r.row[7:0];
			3: b = r.row[15:8];
			default: b = r.row[23:16];
		endcase
		return b;
	endfunction : addr_byte

	// Pin sequence of each operation, one step per index.
	function automatic nand_host_pkg::step_t step_of(input nand_host_pkg::req_t r, input int i);
		nand_host_pkg::step_t s;
		nand_host_pkg::req_t p0;
		nand_host_pkg::req_t p1;
		s = '{kind: nand_host_pkg::K_DONE, data: 8'h00};
		p0 = r;
		p1 = r;
		p0.row[nand_host_pkg::ROW_PLANE_BIT] = 1'b0;
		p1.row[nand_host_pkg::ROW_PLANE_BIT] = 1'b1;
		unique case (r.op)
			nand_host_pkg::OP_PAGE_READ: begin
				if (i == 0) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_READ_SETUP};
				else if (i <= 5) s = '{nand_host_pkg::K_ADDR, addr_byte(r, i - 1)};
				else if (i == 6) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_READ_CONFIRM};
				else if (i == 7) s = '{nand_host_pkg::K_BUSY, 8'h00};
				else if (i == 8) s = '{nand_host_pkg::K_READ, 8'h00};
			end
			// Random cache read; the device drops the column bytes.
			nand_host_pkg::OP_CACHE_RANDOM: begin
				if (i == 0) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_READ_SETUP};
				else if (i <= 5) s = '{nand_host_pkg::K_ADDR, addr_byte(r, i - 1)};
				else if (i == 6) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_CACHE_NEXT};
				else if (i == 7) s = '{nand_host_pkg::K_BUSY, 8'h00};
				else if (i == 8) s = '{nand_host_pkg::K_READ, 8'h00};
			end
			// Continue or end the cache read, then wait out the cache busy time.
			nand_host_pkg::OP_CACHE_SEQ, nand_host_pkg::OP_CACHE_LAST: begin
				if (i == 0) s = '{nand_host_pkg::K_CMD, (r.op == nand_host_pkg::OP_CACHE_SEQ) ?
					nand_host_pkg::CMD_CACHE_NEXT : nand_host_pkg::CMD_CACHE_LAST};
				else if (i == 1) s = '{nand_host_pkg::K_BUSY, 8'h00};
				else if (i == 2) s = '{nand_host_pkg::K_READ, 8'h00};
			end
			// Both address sets come from one row, only the plane bit differs.
			nand_host_pkg::OP_TWO_PLANE: begin
				if (i == 0 || i == 6) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_READ_SETUP};
				else if (i <= 5) s = '{nand_host_pkg::K_ADDR, addr_byte(p0, i - 1)};
				else if (i <= 11) s = '{nand_host_pkg::K_ADDR, addr_byte(p1, i - 7)};
				else if (i == 12) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_READ_CONFIRM};
				else if (i == 13) s = '{nand_host_pkg::K_BUSY, 8'h00};
			end
			// Column change, also usable during parameter page output.
			nand_host_pkg::OP_COL_CHANGE: begin
				if (i == 0) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_COL_CHANGE};
				else if (i <= 2) s = '{nand_host_pkg::K_ADDR, addr_byte(r, i - 1)};
				else if (i == 3) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_OUT_CONFIRM};
				else if (i == 4) s = '{nand_host_pkg::K_WAIT, 8'h00};
				else if (i == 5) s = '{nand_host_pkg::K_READ, 8'h00};
			end
			// Plane select is only sent once the device shows ready.
			nand_host_pkg::OP_PLANE_SELECT: begin
				if (i == 0) s = '{nand_host_pkg::K_BUSY, 8'h00};
				else if (i == 1) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_PLANE_SELECT};
				else if (i <= 6) s = '{nand_host_pkg::K_ADDR, addr_byte(r, i - 2)};
				else if (i == 7) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_OUT_CONFIRM};
				else if (i == 8) s = '{nand_host_pkg::K_WAIT, 8'h00};
				else if (i == 9) s = '{nand_host_pkg::K_READ, 8'h00};
			end
			// Identification, address byte picks device or signature mode.
			nand_host_pkg::OP_IDENT_DEVICE, nand_host_pkg::OP_IDENT_SIGNATURE: begin
				if (i == 0) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_READ_IDENT};
				else if (i == 1) s = '{nand_host_pkg::K_ADDR, (r.op == nand_host_pkg::OP_IDENT_DEVICE) ?
					nand_host_pkg::IDENT_ADDR_DEVICE : nand_host_pkg::IDENT_ADDR_SIGNATURE};
				else if (i == 2) s = '{nand_host_pkg::K_WAIT, 8'h00};
				else if (i == 3) s = '{nand_host_pkg::K_READ, 8'h00};
			end
			// Parameter page; the count decides how many bytes are read.
			nand_host_pkg::OP_PARAM_PAGE: begin
				if (i == 0) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_PARAM_PAGE};
				else if (i == 1) s = '{nand_host_pkg::K_ADDR, nand_host_pkg::PARAM_ADDR};
				else if (i == 2) s = '{nand_host_pkg::K_BUSY, 8'h00};
				else if (i == 3) s = '{nand_host_pkg::K_READ, 8'h00};
			end
			// Only the plain status command exists here, never the enhanced one.
			nand_host_pkg::OP_STATUS: begin
				if (i == 0) s = '{nand_host_pkg::K_CMD, nand_host_pkg::CMD_STATUS};
				else if (i == 1) s = '{nand_host_pkg::K_WAIT, 8'h00};
				else if (i == 2) s = '{nand_host_pkg::K_READ, 8'h00};
			end
			default: s = '{nand_host_pkg::K_DONE, 8'h00};
		endcase
		return s;
	endfunction : step_of

	state_t state, next_state;
	nand_host_pkg::req_t req, next_req;
	logic [3:0] idx, next_idx;
	logic [7:0] timer, next_timer;
	logic [15:0] left, next_left;
	logic ce_n, cle, ale, we_n, re_n, oe_n, done, cache_rdy, array_rdy;
	logic next_ce_n, next_cle, next_ale, next_we_n, next_re_n, next_oe_n, next_done;
	logic next_cache_rdy, next_array_rdy;
	logic [7:0] io_drv, next_io_drv;
	logic [DATA_WIDTH-1:0] io_meta, io_sync, push_data;
	logic rb_meta, rb_sync, push, buf_ready;
	nand_host_pkg::step_t st;
	logic [15:0] read_len;
	logic is_ident;

	// Pins come from another timing world, so each passes two flops before use.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			io_meta <= '0;
			io_sync <= '0;
			rb_meta <= 1'b0;
			rb_sync <= 1'b0;
		end else begin
			io_meta <= io_in;
			io_sync <= io_meta;
			rb_meta <= ready_busy_in;
			rb_sync <= rb_meta;
		end
	end

	// Sequencer: walks the step list and shapes every strobe.
	always_comb begin
		next_state = state;
		next_req = req;
		next_idx = idx;
		next_timer = timer;
		next_left = left;
		next_ce_n = ce_n;
		next_cle = cle;
		next_ale = ale;
		next_we_n = we_n;
		next_re_n = re_n;
		next_oe_n = oe_n;
		next_io_drv = io_drv;
		next_done = 1'b0;
		next_cache_rdy = cache_rdy;
		next_array_rdy = array_rdy;
		push = 1'b0;
		st = step_of(req, int'(idx));
		is_ident = (req.op == nand_host_pkg::OP_IDENT_DEVICE) || (req.op == nand_host_pkg::OP_IDENT_SIGNATURE);
		// Identification lengths are fixed, whatever count the user gave.
		if (req.op == nand_host_pkg::OP_IDENT_DEVICE) read_len = nand_host_pkg::IDENT_DEVICE_LEN;
		else if (req.op == nand_host_pkg::OP_IDENT_SIGNATURE) read_len = nand_host_pkg::IDENT_SIGNATURE_LEN;
		else if (req.op == nand_host_pkg::OP_STATUS) read_len = nand_host_pkg::STATUS_LEN;
		else read_len = req.count;
		// Wide parts define identification only on the low byte lanes.
		push_data = io_sync;
		if (is_ident) push_data = {{(DATA_WIDTH - 8){1'b0}}, io_sync[7:0]};
		unique case (state)
			S_IDLE: begin
				if (req_valid_in) begin
					next_req = req_in;
					next_idx = 4'h0;
					next_ce_n = 1'b0;
					next_state = S_STEP;
				end
			end
			S_STEP: begin
				unique case (st.kind)
					nand_host_pkg::K_CMD, nand_host_pkg::K_ADDR: begin
						next_cle = (st.kind == nand_host_pkg::K_CMD);
						next_ale = (st.kind == nand_host_pkg::K_ADDR);
						next_io_drv = st.data;
						next_oe_n = 1'b0;
						next_we_n = 1'b0;
						next_timer = 8'(nand_host_pkg::WE_LOW_CYC - 1);
						next_state = S_WR_LO;
					end
					nand_host_pkg::K_BUSY: begin
						next_timer = 8'(nand_host_pkg::WE_TO_BUSY_CYC - 1);
						next_state = S_WB;
					end
					nand_host_pkg::K_WAIT: begin
						next_timer = 8'(nand_host_pkg::WRITE_TO_READ_CYC - 1);
						next_state = S_WAIT;
					end
					nand_host_pkg::K_READ: begin
						next_left = read_len;
						next_state = S_RD_ARM;
					end
					nand_host_pkg::K_DONE: begin
						next_ce_n = 1'b1;
						next_done = 1'b1;
						next_state = S_IDLE;
					end
				endcase
			end
			S_WR_LO: begin
				next_timer = timer - 8'h01;
				if (timer == 8'h00) begin
					next_we_n = 1'b1;
					next_timer = 8'(nand_host_pkg::WE_HIGH_CYC - 1);
					next_state = S_WR_HI;
				end
			end
			S_WR_HI: begin
				next_timer = timer - 8'h01;
				if (timer == 8'h00) begin
					next_cle = 1'b0;
					next_ale = 1'b0;
					next_oe_n = 1'b1;
					next_idx = idx + 4'h1;
					next_state = S_STEP;
				end
			end
			// Give the device time to pull busy low before it is watched.
			S_WB: begin
				next_timer = timer - 8'h01;
				if (timer == 8'h00) next_state = S_BUSY;
			end
			// Busy low covers the array or cache transfer; wait for its release.
			S_BUSY: begin
				if (rb_sync) begin
					next_idx = idx + 4'h1;
					next_state = S_STEP;
				end
			end
			// Hold off the first read strobe for the write-to-read delay.
			S_WAIT: begin
				next_timer = timer - 8'h01;
				if (timer == 8'h00) begin
					next_idx = idx + 4'h1;
					next_state = S_STEP;
				end
			end
			// Strobes run from the current column; a full buffer stalls the next strobe.
			S_RD_ARM: begin
				if (left == 16'h0000) begin
					next_idx = idx + 4'h1;
					next_state = S_STEP;
				end else if (buf_ready) begin
					next_re_n = 1'b0;
					next_timer = 8'(nand_host_pkg::RE_LOW_CYC + nand_host_pkg::SYNC_STAGES - 1);
					next_state = S_RD_LO;
				end
			end
			// Low time is stretched by the synchroniser depth so the sampled byte is the driven one.
			S_RD_LO: begin
				next_timer = timer - 8'h01;
				if (timer == 8'h00) begin
					push = 1'b1;
					next_re_n = 1'b1;
					next_left = left - 16'h0001;
					next_timer = 8'(nand_host_pkg::RE_HIGH_CYC - 1);
					next_state = S_RD_HI;
					// Status bit six tracks the cache, bit five the array.
					if (req.op == nand_host_pkg::OP_STATUS) begin
						next_cache_rdy = io_sync[nand_host_pkg::STATUS_CACHE_BIT];
						next_array_rdy = io_sync[nand_host_pkg::STATUS_ARRAY_BIT];
					end
				end
			end
			S_RD_HI: begin
				next_timer = timer - 8'h01;
				if (timer == 8'h00) next_state = S_RD_ARM;
			end
		endcase
	end

	// Sequencer registers; strobes idle high, bus released.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= S_IDLE;
			req <= '0;
			idx <= 4'h0;
			timer <= 8'h00;
			left <= 16'h0000;
			ce_n <= 1'b1;
			cle <= 1'b0;
			ale <= 1'b0;
			we_n <= 1'b1;
			re_n <= 1'b1;
			oe_n <= 1'b1;
			io_drv <= 8'h00;
			done <= 1'b0;
			cache_rdy <= 1'b0;
			array_rdy <= 1'b0;
		end else begin
			state <= next_state;
			req <= next_req;
			idx <= next_idx;
			timer <= next_timer;
			left <= next_left;
			ce_n <= next_ce_n;
			cle <= next_cle;
			ale <= next_ale;
			we_n <= next_we_n;
			re_n <= next_re_n;
			oe_n <= next_oe_n;
			io_drv <= next_io_drv;
			done <= next_done;
			cache_rdy <= next_cache_rdy;
			array_rdy <= next_array_rdy;
		end
	end

	// Output pins and handshakes.
	always_comb begin
		req_ready_out = (state == S_IDLE);
		done_out = done;
		cache_ready_out = cache_rdy;
		array_ready_out = array_rdy;
		ce_n_out = ce_n;
		cle_out = cle;
		ale_out = ale;
		we_n_out = we_n;
		read_strobe_n_out = re_n;
		io_oe_n_out = oe_n;
		io_out = {{(DATA_WIDTH - 8){1'b0}}, io_drv};
	end

	// Read bytes wait here so a slow consumer only pauses the strobes.
	read_buffer #(
		.WIDTH(DATA_WIDTH),
		.DEPTH(BUFFER_DEPTH)
	) u_buffer (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.in_valid_in(push),
		.in_ready_out(buf_ready),
		.in_data_in(push_data),
		.out_valid_out(data_valid_out),
		.out_ready_in(data_ready_in),
		.out_data_out(data_out)
	);

endmodule : nand_read_host

/* File: tb/nand_read_host_sva.sv */
// Port-level protocol checks for the NAND read host.
`timescale 1ns/10ps
module nand_read_host_sva #(
	parameter int DATA_WIDTH = 8
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_in,
	// User side.
	input wire logic req_valid_in,
	input wire logic req_ready_out,
	input wire logic done_out,
	input wire logic data_valid_out,
	input wire logic data_ready_in,
	input wire logic [DATA_WIDTH-1:0] data_out,
	// Flash pins.
	input wire logic ce_n_out,
	input wire logic cle_out,
	input wire logic ale_out,
	input wire logic we_n_out,
	input wire logic read_strobe_n_out,
	input wire logic [DATA_WIDTH-1:0] io_out,
	input wire logic io_oe_n_out,
	input wire logic ready_busy_in
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	// Every strobe belongs to a selected chip.
	property p_ce_strobe;
		(!we_n_out || !read_strobe_n_out) |-> !ce_n_out;
	endproperty
	a_ce_strobe: assert property (p_ce_strobe) else $error("strobe without chip enable");
	property p_write_drive;
		!we_n_out |-> !io_oe_n_out && (cle_out ^ ale_out) && read_strobe_n_out;
	endproperty
	a_write_drive: assert property (p_write_drive) else $error("write cycle not driven");
	property p_read_len;
		$fell(read_strobe_n_out) |-> !read_strobe_n_out [*3] ##1 read_strobe_n_out;
	endproperty
	a_read_len: assert property (p_read_len) else $error("read strobe length");
	// A read strobe only after the flash has shown ready long enough to be seen.
	property p_busy_gate;
		$fell(read_strobe_n_out) |-> ready_busy_in && $past(ready_busy_in, 2);
	endproperty
	a_busy_gate: assert property (p_busy_gate) else $error("strobe while busy");
	property p_wtr;
		cle_out && !we_n_out && io_out[7:0] == 8'hE0 |-> read_strobe_n_out [*5];
	endproperty
	a_wtr: assert property (p_wtr) else $error("strobe too soon after confirm");
	property p_no_enh_status;
		cle_out |-> io_out[7:0] != 8'h78;
	endproperty
	a_no_enh_status: assert property (p_no_enh_status) else $error("enhanced status issued");
	property p_done_pulse;
		done_out |=> !done_out;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
	property p_taken;
		req_valid_in && req_ready_out |=> !req_ready_out;
	endproperty
	a_taken: assert property (p_taken) else $error("ready after taking");
	// A stalled word must not change or vanish, or the reader loses it.
	property p_hold;
		data_valid_out && !data_ready_in |=> data_valid_out && $stable(data_out);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled word changed");
endmodule : nand_read_host_sva

/* File: tb/nand_flash_model.sv */
// Behavioural flash device answering the read-path commands on its pins.
`timescale 1ns/10ps
module nand_flash_model #(
	parameter logic [39:0] DEV_ID = 40'h0102030405, // Arbitrary values.
	parameter logic [31:0] SIG = 32'h0A0B0C0D, // Arbitrary values.
	parameter int BUSY_NS = 400
) (
	// Host driven pins.
	input wire logic ce_n_in,
	input wire logic cle_in,
	input wire logic ale_in,
	input wire logic we_n_in,
	input wire logic read_strobe_n_in,
	input wire logic [7:0] io_in,
	// Device driven pins.
	output logic [7:0] io_out,
	output logic ready_busy_out
);
	logic [7:0] cmd = 8'hFF;
	logic [7:0] adr [5];
	logic [23:0] cache_page = 24'h000000;
	logic [23:0] data_page = 24'h000000;
	logic [1:0] status = 2'h3;
	int n = 0;
	int col = 0;
	int mode = 0;
	initial ready_busy_out = 1'b1;
	initial io_out = 8'hFF;

	// Byte under the read pointer for the current output mode.
	function automatic logic [7:0] out_byte();
		int c;
		c = col % 256;
		case (mode)
			1: return DEV_ID[39-8*col -: 8];
			2: return SIG[31-8*col -: 8];
			3: return (c < 4) ? SIG[31-8*c -: 8] : 8'(c);
			4: return {1'b0, status, 5'h00};
			default: return cache_page[7:0] + 8'(col);
		endcase
	endfunction : out_byte

	task automatic go_busy(input logic [1:0] done_status);
		ready_busy_out = 1'b0;
		status = 2'h0;
		#(BUSY_NS);
		status = done_status;
		ready_busy_out = 1'b1;
	endtask : go_busy

	// Commands and addresses latch on the rising write strobe; busy blocks further latching.
	always @(posedge we_n_in) begin
		if (!ce_n_in && ale_in) begin
			adr[n % 5] = io_in;
			n++;
			col = 0;
			if (cmd == 8'h90) mode = (io_in == 8'h20) ? 2 : 1;
			if (cmd == 8'hEC) begin
				go_busy(2'h3);
				mode = 3;
			end
		end else if (!ce_n_in && cle_in) begin
			case (io_in)
				8'h30: begin
					data_page = {adr[4], adr[3], adr[2]};
					go_busy(2'h3);
					cache_page = data_page;
					mode = 0;
				end
				8'h31, 8'h3F: begin
					cache_page = data_page;
					if (io_in == 8'h3F) go_busy(2'h3);
					else begin
						data_page = (n == 5) ? {adr[4], adr[3], adr[2]} : {data_page[23:6], data_page[5:0] + 6'h01};
						go_busy(2'h2);
					end
					col = 0;
					mode = 0;
				end
				8'hE0: begin
					col = {adr[1], adr[0]};
					if (cmd == 8'h06) cache_page = {adr[4], adr[3], adr[2]};
					if (cmd == 8'h06) mode = 0;
				end
				8'h70: mode = 4;
				default: ;
			endcase
			cmd = io_in;
			n = 0;
		end
	end

	always @(negedge read_strobe_n_in) if (!ce_n_in) io_out = out_byte();
	// Five nanoseconds after the strobe rises the hold is over, so the bus shows the inverse, not the last byte.
	always @(posedge read_strobe_n_in) begin
		if (!ce_n_in) begin
			col++;
			#5 io_out = ~io_out;
		end
	end
endmodule : nand_flash_model

/* File: tb/test_nand_cache_plane_read_id.sv */
// Self-checking bench of the NAND read host against the behavioural flash.
`timescale 1ns/10ps
module test_nand_cache_plane_read_id;
	localparam logic [39:0] DEV_ID = 40'hC1C2C3C4C5; // Arbitrary values.
	localparam logic [31:0] SIG = 32'hA1A2A3A4; // Arbitrary values.
	localparam logic [23:0] R = 24'h0012BE;
	localparam logic [23:0] Q = 24'h000345;
	logic clk_in, rst_in, req_valid_in, req_ready_out, done_out, data_valid_out, data_ready_in;
	logic cache_ready_out, array_ready_out, ce_n_out, cle_out, ale_out, we_n_out, read_strobe_n_out;
	logic io_oe_n_out, ready_busy_in;
	logic [7:0] data_out, io_out, io_in;
	nand_host_pkg::req_t req_in;
	int fail_count = 0;
	int total_checks = 0;
	logic [7:0] got [$];
	logic [7:0] want [$];

	nand_read_host dut_u (.clk_in, .rst_in, .req_valid_in, .req_ready_out, .req_in, .done_out, .data_valid_out,
		.data_ready_in, .data_out, .cache_ready_out, .array_ready_out, .ce_n_out, .cle_out, .ale_out, .we_n_out,
		.read_strobe_n_out, .io_out, .io_oe_n_out, .io_in, .ready_busy_in);
	nand_flash_model #(.DEV_ID(DEV_ID), .SIG(SIG)) flash_u (.ce_n_in(ce_n_out), .cle_in(cle_out),
		.ale_in(ale_out), .we_n_in(we_n_out), .read_strobe_n_in(read_strobe_n_out), .io_in(io_out),
		.io_out(io_in), .ready_busy_out(ready_busy_in));

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	task automatic wrap_up();
		if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up

	task automatic bad(input string msg);
		fail_count++;
		$display("BAD %0t %s", $time, msg);
	endtask : bad

	// Page bytes as the flash lays them out.
	function automatic void page(input logic [23:0] row, input int col, input int cnt);
		for (int i = 0; i < cnt; i++) want.push_back(row[7:0] + 8'(col + i));
	endfunction : page

	// One request; a stall holds the reader off so the two-entry buffer fills and refuses.
	task automatic run(input nand_host_pkg::op_t op, input logic [15:0] col, input logic [23:0] row,
		input logic [15:0] cnt, input bit stall);
		int k;
		int tail;
		tail = 0;
		got.delete();
		req_in <= '{op: op, col: col, row: row, count: cnt};
		req_valid_in <= 1'b1;
		data_ready_in <= !stall;
		@(posedge clk_in);
		req_valid_in <= 1'b0;
		for (k = 0; k < 3000 && tail < 6; k++) begin
			@(posedge clk_in);
			tail += (done_out || tail > 0) ? 1 : 0;
			if (k == 400) data_ready_in <= 1'b1;
			if (data_valid_out && data_ready_in) got.push_back(data_out);
		end
		total_checks++;
		if (k >= 3000) bad("no completion");
		if (got.size() != want.size()) bad("byte count");
		else foreach (want[i]) if (got[i] !== want[i]) bad("byte value");
		want.delete();
	endtask : run

	task automatic t_status(input logic c, input logic a);
		want.push_back({1'b0, c, a, 5'h00});
		run(nand_host_pkg::OP_STATUS, 16'h0000, 24'h000000, 16'h0001, 1'b0);
		total_checks++;
		if (cache_ready_out !== c || array_ready_out !== a) bad("status bits");
	endtask : t_status

	// Cache chain across a block wrap, then a column change.
	task automatic t_cache();
		page(R, 0, 4);
		run(nand_host_pkg::OP_PAGE_READ, 16'h0000, R, 16'h0004, 1'b1);
		page(R, 0, 3);
		run(nand_host_pkg::OP_CACHE_SEQ, 16'h0000, 24'h000000, 16'h0003, 1'b0);
		t_status(1'b1, 1'b0);
		page(R + 24'h000001, 0, 2);
		run(nand_host_pkg::OP_CACHE_SEQ, 16'h0000, 24'h000000, 16'h0002, 1'b0);
		page({R[23:6], 6'h00}, 0, 2);
		run(nand_host_pkg::OP_CACHE_RANDOM, 16'h0033, Q, 16'h0002, 1'b0);
		page(Q, 0, 2);
		run(nand_host_pkg::OP_CACHE_LAST, 16'h0000, 24'h000000, 16'h0002, 1'b0);
		page(Q, 261, 2);
		run(nand_host_pkg::OP_COL_CHANGE, 16'h0105, 24'h000000, 16'h0002, 1'b0);
		t_status(1'b1, 1'b1);
	endtask : t_cache

	task automatic t_plane();
		run(nand_host_pkg::OP_TWO_PLANE, 16'h0000, R, 16'h0000, 1'b0);
		t_status(1'b1, 1'b1);
		page(R | 24'h000040, 3, 2);
		run(nand_host_pkg::OP_PLANE_SELECT, 16'h0003, R | 24'h000040, 16'h0002, 1'b0);
		page(R, 0, 1);
		run(nand_host_pkg::OP_PLANE_SELECT, 16'h0000, R, 16'h0001, 1'b0);
	endtask : t_plane

	task automatic t_ident();
		for (int i = 4; i >= 0; i--) want.push_back(DEV_ID[8*i +: 8]);
		run(nand_host_pkg::OP_IDENT_DEVICE, 16'h0000, 24'h000000, 16'h0005, 1'b0);
		for (int i = 3; i >= 0; i--) want.push_back(SIG[8*i +: 8]);
		run(nand_host_pkg::OP_IDENT_SIGNATURE, 16'h0000, 24'h000000, 16'h0004, 1'b0);
	endtask : t_ident

	// The copy at column 256 must repeat the start of the structure.
	task automatic t_param();
		for (int i = 3; i >= 0; i--) want.push_back(SIG[8*i +: 8]);
		want.push_back(8'h04);
		run(nand_host_pkg::OP_PARAM_PAGE, 16'h0000, 24'h000000, 16'h0005, 1'b1);
		want.push_back(SIG[31:24]);
		want.push_back(SIG[23:16]);
		run(nand_host_pkg::OP_COL_CHANGE, 16'h0100, 24'h000000, 16'h0002, 1'b0);
	endtask : t_param

	initial begin
		rst_in = 1'b1;
		req_valid_in = 1'b0;
		data_ready_in = 1'b1;
		req_in = '0;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		t_cache();
		t_plane();
		t_ident();
		t_param();
		wrap_up();
	end

	// The whole run needs some thousands of cycles; a millisecond means a hang.
	initial begin
		#1000000;
		bad("watchdog");
		wrap_up();
	end
endmodule : test_nand_cache_plane_read_id

bind nand_read_host nand_read_host_sva #(.DATA_WIDTH(DATA_WIDTH)) chk_u (.clk_in, .rst_in, .req_valid_in,
	.req_ready_out, .done_out, .data_valid_out, .data_ready_in, .data_out, .ce_n_out, .cle_out, .ale_out,
	.we_n_out, .read_strobe_n_out, .io_out, .io_oe_n_out, .ready_busy_in);
